/* File: src/viu_params.svh */
// Offsets, field positions, reset values and timing counts of the vectored interrupt unit
`ifndef VIU_PARAMS_SVH
`define VIU_PARAMS_SVH
`define VIU_AW 4
`define VIU_DW 16
`define VIU_OFF_ENABLE 4'h0
`define VIU_OFF_PENDING 4'h1
`define VIU_OFF_CONDITION 4'h2
`define VIU_OFF_STATUS 4'h3
`define VIU_OFF_SERIAL 4'h4
`define VIU_OFF_EXTCFG 4'h5
`define VIU_OFF_CAP_A 4'h6
`define VIU_OFF_CAP_B 4'h7
`define VIU_OFF_CAP_C 4'h8
`define VIU_OFF_CAP_EXT 4'h9
`define VIU_OFF_COUNT 4'ha
`define VIU_OFF_COUNT2 4'hb
`define VIU_BIT_GIE 0
`define VIU_BIT_SAVED 0
`define VIU_BIT_RX_EN 0
`define VIU_BIT_TX_EN 1
`define VIU_NMI 1
`define VIU_EDGE_LO 2
`define VIU_EDGE_HI 4
`define VIU_TIMER 5
`define VIU_SERIAL 6
`define VIU_EXT 7
`define VIU_NSRC 8
`define VIU_VEC_TOP 16'hfffe
`define VIU_PUSH_STEP 16'h0002
`define VIU_DIV 16
`define VIU_DIV_W 4
`define VIU_EN_RST 8'h00
`define VIU_PEND_RST 8'h00
`define VIU_COND_RST 3'h0
`define VIU_EXTCFG_RST 2'h0
`define VIU_SERIAL_RST 2'h0
`define VIU_ZERO16 16'h0000
`endif

/* File: src/viu_pkg.sv */
// Types shared by the vectored interrupt unit
package viu_pkg;
  typedef enum logic [1:0] {VIU_RISE, VIU_FALL, VIU_HIGH, VIU_LOW} viu_ext_mode_t;
  typedef enum {VIU_S_IDLE, VIU_S_PUSH, VIU_S_FETCH, VIU_S_WAIT} viu_state_t;
  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [15:0] wdata;
  } viu_mem_req_t;
  typedef struct packed {
    logic rd;
    logic wr;
    logic [3:0] addr;
    logic [15:0] wdata;
  } viu_reg_req_t;
endpackage

/* File: src/viu_core.sv */
// Vectored interrupt unit: pending flags, arbitration, entry sequence and input capture
//
// Operation
// - Eight sources, two-byte vectors from FFFE (rank 0) down to FFF0 (rank 7).
// - Simultaneous requests: lowest rank number served first; reset always wins.
// - Interrupts wait for instruction end; reset acts at once.
// - Reset and shared serial-vector pin are active-low level inputs.
// - Configurable pin triggers on rising, falling, high or low.
// - Non-maskable pin on rising edge; the three edge pins edge triggered.
// - Each of three edge pins has its own rising/falling select bit.
// - Serial vector uses pin when rx and tx enables clear, else serial events.
// - Reset and non-maskable ignore enables; others have own enable bits.
// - Maskable source requests only with its enable and global enable set.
// - One pending flag per vector, set even when disabled, no order kept.
// - Hardware clears maskable external pending flags after their service.
// - Non-maskable flag read-only; edge pin flags clear on zero, ignore one.
// - Acknowledge pushes program counter, stack pointer advances by two.
// - Acknowledge saves global enable in status word, then clears it.
// - After push, program counter loads from winning vector word.
// - Interrupt return restores enable if saved bit set; plain return only pops.
// - Reset floats ports A and B, drives port P low, fetches reset vector.
// - Three capture registers latch divide-by-16 counter on their pin edge.
// - Fourth capture latches second counter on configured event of configurable pin.
//
// The placing of the registers and the strobed register port were decided locally.
`timescale 1ns/10ps
`include "viu_params.svh"
module viu_core (
  input wire logic clk,
  input wire logic rstn,
  input wire viu_pkg::viu_reg_req_t reg_req,
  output logic [15:0] reg_rdata,
  input wire logic nonmaskable_pin,
  input wire logic edge_irq_pin_a,
  input wire logic edge_irq_pin_b,
  input wire logic edge_irq_pin_c,
  input wire logic configurable_irq_pin,
  input wire logic shared_serial_vector_pin,
  input wire logic timer_overflow,
  input wire logic serial_rx_done,
  input wire logic serial_tx_done,
  input wire logic instr_done,
  input wire logic irq_return_instr,
  input wire logic plain_return_instr,
  input wire logic [15:0] core_pc,
  input wire logic [15:0] core_sp,
  output viu_pkg::viu_mem_req_t mem_req,
  input wire logic [15:0] mem_rdata,
  output logic pc_load,
  output logic [15:0] pc_next,
  output logic sp_load,
  output logic [15:0] sp_next,
  output logic entry_busy,
  output logic port_ab_oe,
  output logic port_p_release
);
  logic [5:0] pin_meta;
  logic [5:0] pin_sync;
  logic [5:0] pin_prev;
  logic [7:0] irq_enable_reg;
  logic [7:0] irq_pending_reg;
  logic [2:0] irq_condition_reg;
  logic saved_global_enable;
  logic [1:0] serial_irq_clock_reg;
  viu_pkg::viu_ext_mode_t ext_capture_config;
  logic [15:0] capture_reg_a;
  logic [15:0] capture_reg_b;
  logic [15:0] capture_reg_c;
  logic [15:0] ext_capture_reg;
  logic [15:0] free_run_counter;
  logic [15:0] second_free_run_counter;
  logic [`VIU_DIV_W-1:0] prescale;
  viu_pkg::viu_state_t state;
  logic reset_entry;
  logic [2:0] win_rank;
  logic [7:0] set_evt;
  logic [7:0] hw_clr;
  logic [7:0] req;
  logic [2:0] rise;
  logic [2:0] fall;
  logic [2:0] edge_hit;
  logic nmi_rise;
  logic ext_rise;
  logic ext_fall;
  logic ext_evt;
  logic ext_cap_evt;
  logic serial_ext_sel;
  logic take;
  logic [2:0] take_rank;
  logic global_irq_enable;
  logic en_wr;
  logic pend_wr;
  logic tick;

  // Vector word address of a rank
  function automatic logic [15:0] viu_vector(input logic [2:0] rank);
    viu_vector = `VIU_VEC_TOP - {12'h000, rank, 1'b0};
  endfunction

  // Lowest set index wins
  function automatic logic [2:0] viu_first(input logic [7:0] r);
    viu_first = 3'h7;
    for (int i = `VIU_NSRC - 1; i >= 0; i--)
    begin
      if (r[i])
        viu_first = 3'(i);
    end
  endfunction

  // Pin order: 0 nmi, 1..3 edge a..c, 4 configurable, 5 shared serial vector
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pin_meta <= 6'h20;
      pin_sync <= 6'h20;
      pin_prev <= 6'h20;
    end
    else
    begin
      pin_meta <= {shared_serial_vector_pin, configurable_irq_pin, edge_irq_pin_c,
                   edge_irq_pin_b, edge_irq_pin_a, nonmaskable_pin};
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  assign nmi_rise = pin_sync[0] & ~pin_prev[0];
  assign ext_rise = pin_sync[4] & ~pin_prev[4];
  assign ext_fall = ~pin_sync[4] & pin_prev[4];

  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : gen_edge
      assign rise[g] = pin_sync[g+1] & ~pin_prev[g+1];
      assign fall[g] = ~pin_sync[g+1] & pin_prev[g+1];
      assign edge_hit[g] = irq_condition_reg[g] ? rise[g] : fall[g];
    end
  endgenerate

  always_comb
  begin
    case (ext_capture_config)
      viu_pkg::VIU_RISE:
      begin
        ext_evt = ext_rise;
        ext_cap_evt = ext_rise;
      end
      viu_pkg::VIU_FALL:
      begin
        ext_evt = ext_fall;
        ext_cap_evt = ext_fall;
      end
      viu_pkg::VIU_HIGH:
      begin
        ext_evt = pin_sync[4];
        ext_cap_evt = ext_rise;
      end
      default:
      begin
        ext_evt = ~pin_sync[4];
        ext_cap_evt = ext_fall;
      end
    endcase
  end

  // Pin wins once both serial interrupt enables are off
  assign serial_ext_sel = ~serial_irq_clock_reg[`VIU_BIT_RX_EN] & ~serial_irq_clock_reg[`VIU_BIT_TX_EN];

  always_comb
  begin
    set_evt = 8'h00;
    set_evt[`VIU_NMI] = nmi_rise;
    set_evt[`VIU_EDGE_HI:`VIU_EDGE_LO] = edge_hit;
    set_evt[`VIU_TIMER] = timer_overflow;
    set_evt[`VIU_SERIAL] = serial_ext_sel ? ~pin_sync[5] : (serial_rx_done | serial_tx_done);
    set_evt[`VIU_EXT] = ext_evt;
  end

  assign global_irq_enable = irq_enable_reg[`VIU_BIT_GIE];
  always_comb
  begin
    req = irq_pending_reg & irq_enable_reg & {8{global_irq_enable}};
    req[0] = 1'b0;
    req[`VIU_NMI] = irq_pending_reg[`VIU_NMI];
  end

  assign take_rank = viu_first(req);
  // Only an instruction boundary lets a request in; reset enters via the sequencer directly
  assign take = (state == viu_pkg::VIU_S_IDLE) & ~reset_entry & instr_done & (|req);

  always_comb
  begin
    hw_clr = 8'h00;
    if (take)
    begin
      hw_clr[take_rank] = (take_rank == 3'(`VIU_NMI)) || (take_rank >= 3'(`VIU_EDGE_LO) && take_rank <= 3'(`VIU_EDGE_HI))
                          || (take_rank == 3'(`VIU_EXT)) || (take_rank == 3'(`VIU_SERIAL) && serial_ext_sel);
    end
  end

  assign en_wr = reg_req.wr && reg_req.addr == `VIU_OFF_ENABLE;
  assign pend_wr = reg_req.wr && reg_req.addr == `VIU_OFF_PENDING;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      irq_pending_reg <= `VIU_PEND_RST;
    else
    begin
      // Set is applied last, so an event in the clearing cycle is kept
      irq_pending_reg[0] <= 1'b0;
      irq_pending_reg[`VIU_NMI] <= (irq_pending_reg[`VIU_NMI] & ~hw_clr[`VIU_NMI]) | set_evt[`VIU_NMI];
      for (int i = `VIU_EDGE_LO; i < `VIU_NSRC; i++)
      begin
        if (pend_wr && i <= `VIU_EDGE_HI)
          irq_pending_reg[i] <= (irq_pending_reg[i] & reg_req.wdata[i] & ~hw_clr[i]) | set_evt[i];
        else if (pend_wr)
          irq_pending_reg[i] <= (reg_req.wdata[i] & ~hw_clr[i]) | set_evt[i];
        else
          irq_pending_reg[i] <= (irq_pending_reg[i] & ~hw_clr[i]) | set_evt[i];
      end
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      irq_enable_reg <= `VIU_EN_RST;
      saved_global_enable <= 1'b0;
    end
    else
    begin
      if (take)
      begin
        saved_global_enable <= global_irq_enable;
        irq_enable_reg <= {irq_enable_reg[7:2], 1'b0, 1'b0};
      end
      else
      begin
        if (reg_req.wr && reg_req.addr == `VIU_OFF_STATUS)
          saved_global_enable <= reg_req.wdata[`VIU_BIT_SAVED];
        if (en_wr)
          irq_enable_reg <= {reg_req.wdata[7:2], 1'b0, reg_req.wdata[`VIU_BIT_GIE]};
        else if (irq_return_instr && saved_global_enable)
          irq_enable_reg[`VIU_BIT_GIE] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      irq_condition_reg <= `VIU_COND_RST;
      serial_irq_clock_reg <= `VIU_SERIAL_RST;
      ext_capture_config <= viu_pkg::VIU_RISE;
    end
    else if (reg_req.wr)
    begin
      if (reg_req.addr == `VIU_OFF_CONDITION)
        irq_condition_reg <= reg_req.wdata[2:0];
      if (reg_req.addr == `VIU_OFF_SERIAL)
        serial_irq_clock_reg <= reg_req.wdata[1:0];
      if (reg_req.addr == `VIU_OFF_EXTCFG)
        ext_capture_config <= viu_pkg::viu_ext_mode_t'(reg_req.wdata[1:0]);
    end
  end

  // Both counters share one prescaler so they stay identical
  assign tick = prescale == `VIU_DIV_W'(`VIU_DIV - 1);
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      prescale <= '0;
      free_run_counter <= `VIU_ZERO16;
      second_free_run_counter <= `VIU_ZERO16;
    end
    else
    begin
      prescale <= prescale + 1'b1;
      if (tick)
      begin
        free_run_counter <= free_run_counter + 16'h0001;
        second_free_run_counter <= second_free_run_counter + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      capture_reg_a <= `VIU_ZERO16;
      capture_reg_b <= `VIU_ZERO16;
      capture_reg_c <= `VIU_ZERO16;
      ext_capture_reg <= `VIU_ZERO16;
    end
    else
    begin
      if (edge_hit[0])
        capture_reg_a <= free_run_counter;
      if (edge_hit[1])
        capture_reg_b <= free_run_counter;
      if (edge_hit[2])
        capture_reg_c <= free_run_counter;
      if (ext_cap_evt)
        ext_capture_reg <= second_free_run_counter;
    end
  end

  // Entry sequence; reset starts at the vector fetch with no push
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state <= viu_pkg::VIU_S_FETCH;
      reset_entry <= 1'b1;
      win_rank <= 3'h0;
      mem_req <= '0;
      pc_load <= 1'b0;
      pc_next <= `VIU_ZERO16;
      sp_load <= 1'b0;
      sp_next <= `VIU_ZERO16;
      entry_busy <= 1'b1;
    end
    else
    begin
      mem_req <= '0;
      pc_load <= 1'b0;
      sp_load <= 1'b0;
      case (state)
        viu_pkg::VIU_S_IDLE:
        begin
          entry_busy <= take;
          if (take)
          begin
            win_rank <= take_rank;
            state <= viu_pkg::VIU_S_PUSH;
          end
        end
        viu_pkg::VIU_S_PUSH:
        begin
          mem_req <= '{rd: 1'b0, wr: 1'b1, addr: core_sp, wdata: core_pc};
          sp_next <= core_sp + `VIU_PUSH_STEP;
          sp_load <= 1'b1;
          state <= viu_pkg::VIU_S_FETCH;
        end
        viu_pkg::VIU_S_FETCH:
        begin
          mem_req <= '{rd: 1'b1, wr: 1'b0, addr: viu_vector(win_rank), wdata: `VIU_ZERO16};
          state <= viu_pkg::VIU_S_WAIT;
        end
        viu_pkg::VIU_S_WAIT:
        begin
          pc_next <= mem_rdata;
          pc_load <= 1'b1;
          reset_entry <= 1'b0;
          entry_busy <= 1'b0;
          state <= viu_pkg::VIU_S_IDLE;
        end
        default:
          state <= viu_pkg::VIU_S_IDLE;
      endcase
    end
  end

  // Ports stay floated and port P low until the reset vector is loaded
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      port_ab_oe <= 1'b0;
      port_p_release <= 1'b0;
    end
    else if (reset_entry && state == viu_pkg::VIU_S_WAIT)
    begin
      port_ab_oe <= 1'b1;
      port_p_release <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      reg_rdata <= `VIU_ZERO16;
    else if (reg_req.rd)
    begin
      case (reg_req.addr)
        `VIU_OFF_ENABLE: reg_rdata <= {8'h00, irq_enable_reg};
        `VIU_OFF_PENDING: reg_rdata <= {8'h00, irq_pending_reg};
        `VIU_OFF_CONDITION: reg_rdata <= {13'h0000, irq_condition_reg};
        `VIU_OFF_STATUS: reg_rdata <= {15'h0000, saved_global_enable};
        `VIU_OFF_SERIAL: reg_rdata <= {14'h0000, serial_irq_clock_reg};
        `VIU_OFF_EXTCFG: reg_rdata <= {14'h0000, ext_capture_config};
        `VIU_OFF_CAP_A: reg_rdata <= capture_reg_a;
        `VIU_OFF_CAP_B: reg_rdata <= capture_reg_b;
        `VIU_OFF_CAP_C: reg_rdata <= capture_reg_c;
        `VIU_OFF_CAP_EXT: reg_rdata <= ext_capture_reg;
        `VIU_OFF_COUNT: reg_rdata <= free_run_counter;
        `VIU_OFF_COUNT2: reg_rdata <= second_free_run_counter;
        default: reg_rdata <= `VIU_ZERO16;
      endcase
    end
    else
      reg_rdata <= `VIU_ZERO16;
  end

  sequence viu_push_s;
    mem_req.wr && sp_load && sp_next == core_sp + `VIU_PUSH_STEP;
  endsequence
  sequence viu_fetch_s(logic [2:0] r);
    mem_req.rd && mem_req.addr == viu_vector(r);
  endsequence

  AST_ENTRY_SEQ: assert property (@(posedge clk) disable iff (!rstn)
    take |=> ##1 viu_push_s ##1 viu_fetch_s($past(take_rank, 3)) ##1 pc_load)
    else $error("entry sequence out of order");
  AST_VECTOR: assert property (@(posedge clk) disable iff (!rstn)
    $rose(pc_load) |-> pc_next == $past(mem_rdata))
    else $error("program counter not loaded from vector word");
  AST_GIE_SAVE: assert property (@(posedge clk) disable iff (!rstn)
    take |=> !irq_enable_reg[`VIU_BIT_GIE] && saved_global_enable == $past(global_irq_enable))
    else $error("global enable not saved and cleared");
  AST_PRIORITY: assert property (@(posedge clk) disable iff (!rstn)
    take |-> req[take_rank] && (take_rank == 3'h0 || (req & ((8'h01 << take_rank) - 8'h01)) == 8'h00))
    else $error("lower rank was pending");
  AST_BOUNDARY: assert property (@(posedge clk) disable iff (!rstn)
    (state == viu_pkg::VIU_S_IDLE && !instr_done) |=> state == viu_pkg::VIU_S_IDLE)
    else $error("interrupt taken inside an instruction");
  AST_MASKED: assert property (@(posedge clk) disable iff (!rstn)
    take && take_rank != 3'(`VIU_NMI) |-> global_irq_enable && irq_enable_reg[take_rank])
    else $error("masked source serviced");
  AST_RETURN: assert property (@(posedge clk) disable iff (!rstn)
    irq_return_instr && saved_global_enable && !take && !en_wr |=> irq_enable_reg[`VIU_BIT_GIE])
    else $error("return did not restore global enable");
  // A plain return only pops, so the global enable must keep its value
  AST_PLAIN_RET: assert property (@(posedge clk) disable iff (!rstn)
    plain_return_instr && !irq_return_instr && !take && !en_wr |=> irq_enable_reg[`VIU_BIT_GIE] == $past(global_irq_enable))
    else $error("plain return changed global enable");
  AST_WRITE_ONE: assert property (@(posedge clk) disable iff (!rstn)
    pend_wr && !irq_pending_reg[`VIU_EDGE_LO] && !set_evt[`VIU_EDGE_LO] |=> !irq_pending_reg[`VIU_EDGE_LO])
    else $error("written one set an edge pending flag");
  AST_EDGE_ONCE: assert property (@(posedge clk) disable iff (!rstn)
    edge_hit[0] |=> !edge_hit[0])
    else $error("one edge detected twice");
  AST_CAPTURE: assert property (@(posedge clk) disable iff (!rstn)
    edge_hit[1] |=> capture_reg_b == $past(free_run_counter))
    else $error("capture missed counter value");
  AST_DIVIDE: assert property (@(posedge clk) disable iff (!rstn)
    !tick ##1 tick |=> free_run_counter == $past(free_run_counter) + 16'h0001)
    else $error("counter step wrong");
endmodule

/* File: dv/viu_far_model.sv */
// Far-side model of the vectored interrupt unit: processor core, stack and vector memory
`timescale 1ns/10ps
module viu_far_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic pause,
  input wire logic slow,
  input wire viu_pkg::viu_mem_req_t mem_req,
  output logic [15:0] mem_rdata,
  input wire logic pc_load,
  input wire logic [15:0] pc_next,
  input wire logic sp_load,
  input wire logic [15:0] sp_next,
  output logic [15:0] core_pc,
  output logic [15:0] core_sp,
  output logic instr_done
);
  logic [15:0] junk;
  logic [1:0] phase;
  // Vector words answer at once; an idle data bus shows a changing pattern so stale data cannot pass
  assign mem_rdata = mem_req.rd ? (mem_req.addr ^ 16'h3c00) : junk;
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      core_pc <= 16'h0100;
      core_sp <= 16'h0200;
      junk <= 16'h5aa5;
      phase <= 2'h0;
      instr_done <= 1'b0;
    end
    else
    begin
      junk <= ~junk;
      phase <= phase + 2'h1;
      // Slow mode makes instruction boundaries rare, pause withholds them entirely
      instr_done <= !pause && (!slow || phase == 2'h3);
      if (pc_load)
        core_pc <= pc_next;
      if (sp_load)
        core_sp <= sp_next;
    end
  end
endmodule

/* File: dv/viu_core_tb.sv */
// Self-checking bench for the vectored interrupt unit
`timescale 1ns/10ps
`include "viu_params.svh"
module viu_core_tb;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  viu_pkg::viu_reg_req_t reg_req;
  viu_pkg::viu_mem_req_t mem_req;
  logic [15:0] reg_rdata, mem_rdata, core_pc, core_sp, pc_next, sp_next;
  logic nonmaskable_pin, configurable_irq_pin, shared_serial_vector_pin;
  logic [2:0] epin;
  logic timer_overflow, serial_rx_done, serial_tx_done, instr_done;
  logic irq_return_instr, plain_return_instr, pc_load, sp_load, entry_busy, port_ab_oe, port_p_release;
  logic pause, slow;
  logic [15:0] rd_val, exp_pc, exp_sp, c0, c1;
  logic [7:0] seed;
  logic [15:0] q_vec[$], q_wa[$], q_wd[$], q_sp[$], q_pc[$];
  int fail_count = 0;
  int checks = 0;
  int cyc = 0;

  always #2.5 clk = ~clk;

  viu_core viu_core_inst (.clk(clk), .rstn(rstn), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .nonmaskable_pin(nonmaskable_pin), .edge_irq_pin_a(epin[0]), .edge_irq_pin_b(epin[1]),
    .edge_irq_pin_c(epin[2]), .configurable_irq_pin(configurable_irq_pin),
    .shared_serial_vector_pin(shared_serial_vector_pin), .timer_overflow(timer_overflow),
    .serial_rx_done(serial_rx_done), .serial_tx_done(serial_tx_done), .instr_done(instr_done),
    .irq_return_instr(irq_return_instr), .plain_return_instr(plain_return_instr), .core_pc(core_pc),
    .core_sp(core_sp), .mem_req(mem_req), .mem_rdata(mem_rdata), .pc_load(pc_load), .pc_next(pc_next),
    .sp_load(sp_load), .sp_next(sp_next), .entry_busy(entry_busy), .port_ab_oe(port_ab_oe),
    .port_p_release(port_p_release));

  viu_far_model viu_far_model_inst (.clk(clk), .rstn(rstn), .pause(pause), .slow(slow), .mem_req(mem_req),
    .mem_rdata(mem_rdata), .pc_load(pc_load), .pc_next(pc_next), .sp_load(sp_load), .sp_next(sp_next),
    .core_pc(core_pc), .core_sp(core_sp), .instr_done(instr_done));

  // Records every memory cycle and load of the entry sequence; counts clocks since release for the counter model
  always @(posedge clk)
  begin
    if (rstn)
      cyc++;
    if (rstn && mem_req.rd)
      q_vec.push_back(mem_req.addr);
    if (rstn && mem_req.wr)
      q_wa.push_back(mem_req.addr);
    if (rstn && mem_req.wr)
      q_wd.push_back(mem_req.wdata);
    if (rstn && sp_load)
      q_sp.push_back(sp_next);
    if (rstn && pc_load)
      q_pc.push_back(pc_next);
  end

  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic test_done();
    if (fail_count == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic cmp(input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // One strobe cycle, then an idle cycle; read data is taken in the cycle after the strobe
  task automatic reg_acc(input logic wr, input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_req <= '{rd: !wr, wr: wr, addr: a, wdata: d};
    @(posedge clk);
    reg_req <= '0;
    #1;
    rd_val = reg_rdata;
  endtask

  task automatic chk_reg(input logic [3:0] a, input logic [15:0] e);
    reg_acc(1'b0, a, 16'h0000);
    cmp(rd_val, e);
  endtask

  // Counter model: one step every divider period, data captured one edge after the strobe
  task automatic chk_count(input logic [3:0] a);
    reg_acc(1'b0, a, 16'h0000);
    cmp(rd_val, 16'((cyc - 1) / `VIU_DIV));
  endtask

  task automatic pulse_ret(input logic irq);
    @(posedge clk);
    irq_return_instr <= irq;
    plain_return_instr <= !irq;
    @(posedge clk);
    irq_return_instr <= 1'b0;
    plain_return_instr <= 1'b0;
  endtask

  task automatic chk_entry(input int rank, input logic push);
    logic [15:0] v;
    int n;
    v = 16'hfffe - 16'(2 * rank);
    n = 0;
    while (q_pc.size() == 0 && n < 100)
    begin
      @(posedge clk);
      n++;
    end
    cmp(16'(q_vec.size() + q_pc.size()), 16'h0002);
    if (q_vec.size() == 0 || q_pc.size() == 0)
      return;
    if (push)
    begin
      cmp(16'(q_wa.size() + q_sp.size()), 16'h0002);
      if (q_wa.size() != 0)
        cmp(q_wa.pop_front(), exp_sp);
      if (q_wd.size() != 0)
        cmp(q_wd.pop_front(), exp_pc);
      if (q_sp.size() != 0)
        cmp(q_sp.pop_front(), exp_sp + 16'h0002);
      exp_sp = exp_sp + 16'h0002;
    end
    cmp(q_vec.pop_front(), v);
    exp_pc = v ^ 16'h3c00;
    cmp(q_pc.pop_front(), exp_pc);
  endtask

  initial
  begin
    reg_req = '0;
    nonmaskable_pin = 1'b0;
    epin = 3'h0;
    configurable_irq_pin = 1'b0;
    shared_serial_vector_pin = 1'b1;
    timer_overflow = 1'b0;
    serial_rx_done = 1'b0;
    serial_tx_done = 1'b0;
    irq_return_instr = 1'b0;
    plain_return_instr = 1'b0;
    pause = 1'b1;
    slow = 1'b0;
    seed = 8'h5e;
    tick(10);
    cmp({13'h0000, port_ab_oe, port_p_release, entry_busy}, 16'h0001);
    tick(10);
    rstn <= 1'b1;
    exp_sp = 16'h0200;
    // No instruction boundary is offered, so the reset vector must be fetched regardless
    chk_entry(0, 1'b0);
    tick(2);
    cmp({13'h0000, port_ab_oe, port_p_release, entry_busy}, 16'h0006);
    chk_reg(`VIU_OFF_ENABLE, `VIU_ZERO16);
    chk_reg(`VIU_OFF_PENDING, `VIU_ZERO16);
    chk_reg(4'hf, `VIU_ZERO16);
    reg_acc(1'b1, 4'hc, 16'hffff);
    chk_reg(4'hc, `VIU_ZERO16);
    reg_acc(1'b1, `VIU_OFF_ENABLE, 16'hffff);
    chk_reg(`VIU_OFF_ENABLE, 16'h00fd);
    reg_acc(1'b1, `VIU_OFF_ENABLE, 16'h0000);
    chk_count(`VIU_OFF_COUNT);
    tick(30);
    chk_count(`VIU_OFF_COUNT);
    chk_count(`VIU_OFF_COUNT2);
    seed = lfsr_next(seed);
    reg_acc(1'b1, `VIU_OFF_CONDITION, {13'h0000, seed[2:0]});
    chk_reg(`VIU_OFF_CONDITION, {13'h0000, seed[2:0]});
    @(posedge clk);
    epin <= ~seed[2:0];
    tick(5);
    reg_acc(1'b1, `VIU_OFF_PENDING, 16'h0000);
    reg_acc(1'b0, `VIU_OFF_COUNT, 16'h0000);
    c0 = rd_val;
    for (int r = 0; r < 2; r++)
    begin
      @(posedge clk);
      epin <= seed[2:0];
      tick(5);
      chk_reg(`VIU_OFF_PENDING, 16'h001c);
      if (r == 0)
      begin
        reg_acc(1'b1, `VIU_OFF_PENDING, 16'h0000);
        chk_reg(`VIU_OFF_PENDING, `VIU_ZERO16);
        @(posedge clk);
        epin <= ~seed[2:0];
        tick(5);
        chk_reg(`VIU_OFF_PENDING, `VIU_ZERO16);
      end
    end
    reg_acc(1'b0, `VIU_OFF_COUNT, 16'h0000);
    c1 = rd_val;
    reg_acc(1'b0, `VIU_OFF_CAP_C, 16'h0000);
    cmp({14'h0000, c0 <= rd_val, rd_val <= c1}, 16'h0003);
    c1 = rd_val;
    // All three edge pins switched together, so every capture holds the same count
    reg_acc(1'b0, `VIU_OFF_CAP_A, 16'h0000);
    cmp(rd_val, c1);
    reg_acc(1'b0, `VIU_OFF_CAP_B, 16'h0000);
    cmp(rd_val, c1);
    @(posedge clk);
    nonmaskable_pin <= 1'b1;
    tick(5);
    reg_acc(1'b1, `VIU_OFF_PENDING, 16'h001c);
    chk_reg(`VIU_OFF_PENDING, 16'h001e);
    reg_acc(1'b1, `VIU_OFF_ENABLE, 16'h001d);
    @(posedge clk);
    pause <= 1'b0;
    slow <= 1'b1;
    chk_entry(1, 1'b1);
    chk_reg(`VIU_OFF_STATUS, 16'h0001);
    chk_reg(`VIU_OFF_ENABLE, 16'h001c);
    pulse_ret(1'b1);
    chk_entry(2, 1'b1);
    pulse_ret(1'b0);
    tick(12);
    chk_reg(`VIU_OFF_ENABLE, 16'h001c);
    cmp(16'(q_pc.size()), 16'h0000);
    pulse_ret(1'b1);
    chk_entry(3, 1'b1);
    pulse_ret(1'b1);
    chk_entry(4, 1'b1);
    chk_reg(`VIU_OFF_PENDING, `VIU_ZERO16);
    // With the saved bit cleared an interrupt return must leave the global enable off
    reg_acc(1'b1, `VIU_OFF_STATUS, 16'h0000);
    chk_reg(`VIU_OFF_STATUS, `VIU_ZERO16);
    pulse_ret(1'b1);
    chk_reg(`VIU_OFF_ENABLE, 16'h001c);
    @(posedge clk);
    nonmaskable_pin <= 1'b0;
    timer_overflow <= 1'b1;
    @(posedge clk);
    timer_overflow <= 1'b0;
    tick(3);
    chk_reg(`VIU_OFF_PENDING, 16'h0020);
    // Peripheral flags stay until software clears them
    reg_acc(1'b1, `VIU_OFF_PENDING, 16'h0000);
    @(posedge clk);
    shared_serial_vector_pin <= 1'b0;
    tick(5);
    chk_reg(`VIU_OFF_PENDING, 16'h0040);
    @(posedge clk);
    shared_serial_vector_pin <= 1'b1;
    reg_acc(1'b1, `VIU_OFF_SERIAL, 16'h0003);
    reg_acc(1'b1, `VIU_OFF_PENDING, 16'h0000);
    @(posedge clk);
    shared_serial_vector_pin <= 1'b0;
    tick(5);
    chk_reg(`VIU_OFF_PENDING, `VIU_ZERO16);
    @(posedge clk);
    serial_rx_done <= 1'b1;
    @(posedge clk);
    serial_rx_done <= 1'b0;
    tick(3);
    chk_reg(`VIU_OFF_PENDING, 16'h0040);
    reg_acc(1'b1, `VIU_OFF_PENDING, 16'h0000);
    @(posedge clk);
    serial_tx_done <= 1'b1;
    @(posedge clk);
    serial_tx_done <= 1'b0;
    shared_serial_vector_pin <= 1'b1;
    tick(3);
    chk_reg(`VIU_OFF_PENDING, 16'h0040);
    for (int m = 0; m < 4; m++)
    begin
      reg_acc(1'b1, `VIU_OFF_EXTCFG, 16'(m));
      @(posedge clk);
      configurable_irq_pin <= m[0];
      tick(5);
      reg_acc(1'b1, `VIU_OFF_PENDING, 16'h0000);
      reg_acc(1'b0, `VIU_OFF_COUNT2, 16'h0000);
      c0 = rd_val;
      @(posedge clk);
      configurable_irq_pin <= !m[0];
      tick(5);
      chk_reg(`VIU_OFF_PENDING, 16'h0080);
      reg_acc(1'b0, `VIU_OFF_CAP_EXT, 16'h0000);
      c1 = rd_val;
      reg_acc(1'b0, `VIU_OFF_COUNT2, 16'h0000);
      cmp({14'h0000, c0 <= c1, c1 <= rd_val}, 16'h0003);
      @(posedge clk);
      configurable_irq_pin <= m[0];
      tick(5);
      reg_acc(1'b1, `VIU_OFF_PENDING, 16'h0000);
      chk_reg(`VIU_OFF_PENDING, `VIU_ZERO16);
    end
    test_done();
  end

  initial
  begin
    #100000;
    fail_count++;
    test_done();
  end
endmodule
